// ==== rtl/uic_top.sv ====
// Purpose: Interrupt enable, prioritised interrupt status and FIFO control of one UART channel.
// Assumes: Host strobes rd_i and wr_i are one-cycle pulses on clk_i; unit inputs share clk_i.
// Notes: Read data appears on rdata_o one cycle after the read strobe.
`include "uic_params.svh"

// Operation
// - All enables clear gives polled mode
// - Line status bits report receive and transmit state
// - Receive ready on character or trigger level
// - Transmit ready on empty, below trigger, enable
// - Transmit ready on FIFO or transmitter empty
// - Line status interrupt on erroneous character
// - Upper enables work only with enhanced bit
// - Interrupt on flow-control pin rising edge
// - Status read shows highest pending interrupt only
// - Six-bit priority codes per interrupt level
// - Receive timeout after four chars twelve bits
// - Modem interrupt on any low change bit
// - Each latched interrupt clears on its own access; receive and modem levels follow their inputs
// - Xoff and special clear on read or character
// - Xoff status holds until Xon received or status read
// - Status bits four and five need enhanced bit
// - Status bit zero low while interrupt pending
// - Top status bits show FIFO enable
// - FIFO control with bit zero clear only disables the FIFO
// - FIFO reset bits clear pointers, self-clear
// - DMA bit selects ready pin behaviour
// - Transmit trigger writable only with enhanced bit
// - Feature bits and fields select trigger table
module uic_top
  import uic_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire uic_rx_type rx_i,
  input wire uic_tx_type tx_i,
  input wire logic [7:0] msr_i,
  input wire logic efr_enable_i,
  input wire logic [1:0] feature_control_reg_table_i,
  input wire logic rs485_auto_i,
  input wire logic auto_rts_i,
  input wire logic auto_cts_i,
  input wire logic rts_out_i,
  input wire logic cts_pin_i,
  input wire logic [7:0] rx_trg_prog_i,
  input wire logic [7:0] tx_trg_prog_i,
  input wire logic bit_tick_i,
  input wire logic [3:0] char_bits_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  output logic fifo_en_o,
  output logic dma_mode_o,
  output logic rx_fifo_reset_o,
  output logic tx_fifo_reset_o,
  output logic receive_ready_pin_n_o,
  output logic transmit_ready_pin_n_o
);

  uic_state_type s;
  uic_state_type next_s;
  logic cts_s1;
  logic cts_s2;
  logic [7:0] rx_trig;
  logic [7:0] tx_trig;
  logic [7:0] ier_eff;
  logic [7:0] line_status_reg;
  logic rx_lvl;
  logic ms_lvl;
  logic tx_evt;
  logic to_run;
  logic [6:0] to_limit;
  logic rd_isr;
  logic rd_lsr;
  logic rd_msr;
  logic rd_rhr;
  logic wr_thr;
  uic_code_type code;

  ////////////////////////////////////////////////////////////////////////////
  // Clear-to-send arrives from a pin and is synchronised first.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cts_s1 <= 1'b0;
      cts_s2 <= 1'b0;
    end else begin
      cts_s1 <= cts_pin_i;
      cts_s2 <= cts_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pick(input logic [31:0] tab, input logic [1:0] sel);
    pick = tab[{sel, 3'b000} +: 8];
  endfunction

  always_comb begin
    unique case (feature_control_reg_table_i)
      2'b00: begin
        rx_trig = pick(`UIC_RXTRG_A, s.rx_sel);
        tx_trig = pick(`UIC_TXTRG_A, s.tx_sel);
      end
      2'b01: begin
        rx_trig = pick(`UIC_RXTRG_B, s.rx_sel);
        tx_trig = pick(`UIC_TXTRG_B, s.tx_sel);
      end
      2'b10: begin
        rx_trig = pick(`UIC_RXTRG_C, s.rx_sel);
        tx_trig = pick(`UIC_TXTRG_C, s.tx_sel);
      end
      2'b11: begin
        rx_trig = rx_trg_prog_i;
        tx_trig = tx_trg_prog_i;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode and source levels.
  always_comb begin
    ier_eff = {s.interrupt_enable[7:4] & {4{efr_enable_i}}, s.interrupt_enable[3:0]};
    rd_isr = rd_i && (addr_i == `UIC_A_ISR);
    rd_lsr = rd_i && (addr_i == `UIC_A_LSR);
    rd_msr = rd_i && (addr_i == `UIC_A_MSR);
    rd_rhr = rd_i && (addr_i == `UIC_A_RHR);
    wr_thr = wr_i && (addr_i == `UIC_A_RHR);
    line_status_reg = {rx_i.fifo_err, tx_i.all_empty, tx_i.thr_empty, rx_i.head_err,
           rx_i.overrun, (rx_i.level != 8'h00)};
    rx_lvl = ier_eff[`UIC_IER_RX] && (s.fifo_en ? (rx_i.level >= rx_trig)
                                                 : (rx_i.level != 8'h00));
    ms_lvl = ier_eff[`UIC_IER_MS] && (|msr_i[3:0]);
    to_limit = 7'(`UIC_TO_CHARS * {3'b000, char_bits_i}) + `UIC_TO_BITS;
    to_run = s.fifo_en && (rx_i.level != 8'h00) && !s.p_rxto && (s.to_cnt != to_limit);
    if (s.p_ls) begin
      code = UIC_CODE_LS;
    end else if (s.p_rxto) begin
      code = UIC_CODE_RXTO;
    end else if (rx_lvl) begin
      code = UIC_CODE_RX;
    end else if (s.p_tx) begin
      code = UIC_CODE_TX;
    end else if (ms_lvl) begin
      code = UIC_CODE_MS;
    end else if ((s.p_xoff || s.p_spec) && efr_enable_i) begin
      code = UIC_CODE_XOFF;
    end else if (s.p_fc && efr_enable_i) begin
      code = UIC_CODE_FC;
    end else begin
      code = UIC_CODE_NONE;
    end
    // Transmit-ready events; RS-485 mode uses transmitter empty in place of FIFO empty.
    if (!s.fifo_en) begin
      tx_evt = tx_i.thr_empty && !s.thr_empty_q;
    end else if (rs485_auto_i) begin
      tx_evt = (tx_i.all_empty && !s.all_empty_q)
               || ((tx_i.level < tx_trig) && s.tx_above_q);
    end else begin
      tx_evt = ((tx_i.level == 8'h00) && !s.tx_empty_q)
               || ((tx_i.level < tx_trig) && s.tx_above_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state computation.
  always_comb begin
    next_s = s;
    next_s.rx_rst = 1'b0;
    next_s.tx_rst = 1'b0;
    if (wr_i && (addr_i == `UIC_A_IER)) begin
      next_s.interrupt_enable = wdata_i;
    end
    if (wr_i && (addr_i == `UIC_A_ISR)) begin
      if (wdata_i[`UIC_FCR_EN]) begin
        next_s.fifo_en = 1'b1;
        next_s.rx_rst = wdata_i[`UIC_FCR_RXRST];
        next_s.tx_rst = wdata_i[`UIC_FCR_TXRST];
        next_s.dma = wdata_i[`UIC_FCR_DMA];
        next_s.rx_sel = wdata_i[7:6];
        if (efr_enable_i) begin
          next_s.tx_sel = wdata_i[5:4];
        end
      end else begin
        next_s.fifo_en = 1'b0;
      end
    end
    // Each flag clears on its access; a coincident set wins.
    if (rd_lsr) begin
      next_s.p_ls = 1'b0;
    end
    if (rx_i.char_stb && (|rx_i.char_err) && ier_eff[`UIC_IER_LS]) begin
      next_s.p_ls = 1'b1;
    end
    if (rd_rhr || rx_i.char_stb) begin
      next_s.to_cnt = 7'h00;
    end else if (to_run && bit_tick_i) begin
      next_s.to_cnt = s.to_cnt + 7'h01;
    end
    if (rd_rhr) begin
      next_s.p_rxto = 1'b0;
    end
    if (to_run && (s.to_cnt == to_limit - 7'h01) && bit_tick_i && ier_eff[`UIC_IER_RX]) begin
      next_s.p_rxto = 1'b1;
    end
    if (wr_thr || (rd_isr && code == UIC_CODE_TX)) begin
      next_s.p_tx = 1'b0;
    end
    if (ier_eff[`UIC_IER_TX] && (tx_evt || (!s.ier_tx_q && tx_i.thr_empty))) begin
      next_s.p_tx = 1'b1;
    end
    if (rx_i.xon_match || (rd_isr && code == UIC_CODE_XOFF)) begin
      next_s.p_xoff = 1'b0;
    end
    if (rx_i.xoff_match && ier_eff[`UIC_IER_XOFF]) begin
      next_s.p_xoff = 1'b1;
    end
    if (rx_i.char_stb || (rd_isr && code == UIC_CODE_XOFF)) begin
      next_s.p_spec = 1'b0;
    end
    if (rx_i.spec_match && ier_eff[`UIC_IER_XOFF]) begin
      next_s.p_spec = 1'b1;
    end
    if (rd_msr) begin
      next_s.p_fc = 1'b0;
    end
    if ((ier_eff[`UIC_IER_RTS] && auto_rts_i && rts_out_i && !s.rts_q)
        || (ier_eff[`UIC_IER_CTS] && auto_cts_i && cts_s2 && !s.cts_q)) begin
      next_s.p_fc = 1'b1;
    end
    next_s.thr_empty_q = tx_i.thr_empty;
    next_s.all_empty_q = tx_i.all_empty;
    next_s.tx_empty_q = (tx_i.level == 8'h00);
    next_s.tx_above_q = (tx_i.level >= tx_trig);
    next_s.ier_tx_q = ier_eff[`UIC_IER_TX];
    next_s.rts_q = rts_out_i;
    next_s.cts_q = cts_s2;
    next_s.irq = (code != UIC_CODE_NONE);
    if (rd_i) begin
      unique case (addr_i)
        `UIC_A_IER: next_s.rdata = s.interrupt_enable;
        `UIC_A_ISR: next_s.rdata = {s.fifo_en, s.fifo_en, code};
        `UIC_A_LSR: next_s.rdata = line_status_reg;
        `UIC_A_MSR: next_s.rdata = msr_i;
        default: next_s.rdata = 8'h00;
      endcase
    end
    if (!s.fifo_en) begin
      next_s.rx_pin_n = !(rx_i.level != 8'h00);
      next_s.tx_pin_n = !tx_i.thr_empty;
    end else if (s.dma) begin
      next_s.rx_pin_n = !((rx_i.level >= rx_trig) || s.p_rxto);
      next_s.tx_pin_n = !(tx_i.level < `UIC_FIFO_DEPTH);
    end else begin
      next_s.rx_pin_n = !(rx_i.level != 8'h00);
      next_s.tx_pin_n = !(tx_i.level == 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.rdata <= 8'h00;
      s.rx_pin_n <= 1'b1;
      s.tx_pin_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign irq_o = s.irq;
  assign fifo_en_o = s.fifo_en;
  assign dma_mode_o = s.dma;
  assign rx_fifo_reset_o = s.rx_rst;
  assign tx_fifo_reset_o = s.tx_rst;
  assign receive_ready_pin_n_o = s.rx_pin_n;
  assign transmit_ready_pin_n_o = s.tx_pin_n;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_irq_follows: assert property ((code != UIC_CODE_NONE) |=> irq_o)
    else $error("interrupt output missed a pending source");
  chk_isr_bit0: assert property (rd_isr && code == UIC_CODE_NONE |=> rdata_o[0])
    else $error("status bit zero low with nothing pending");
  chk_isr_fifo: assert property (rd_isr |=> rdata_o[7:6] == {2{$past(s.fifo_en)}})
    else $error("top status bits differ from FIFO enable");
  chk_reset_pulse: assert property (rx_fifo_reset_o |=> !rx_fifo_reset_o)
    else $error("receive FIFO reset lasted over one cycle");
  chk_fcr_ignored: assert property (wr_i && addr_i == `UIC_A_ISR && !wdata_i[0]
    |=> !fifo_en_o && $stable(dma_mode_o))
    else $error("FIFO control bits taken without enable bit");
  chk_tx_clear: assert property (wr_thr && !(tx_evt || (!s.ier_tx_q && tx_i.thr_empty)) |=> !s.p_tx)
    else $error("transmit ready not cleared by holding write");
  chk_ls_set: assert property (rx_i.char_stb && rx_i.char_err[0] && ier_eff[2] |=> s.p_ls ##1 irq_o)
    else $error("line status interrupt not raised");
  chk_xoff_hold: assert property (s.p_xoff && !rx_i.xon_match && !rd_isr |=> s.p_xoff)
    else $error("Xoff status dropped before Xon");
  chk_ls_first: assert property (s.p_ls |-> code == UIC_CODE_LS)
    else $error("line status not highest priority");

endmodule // uic_top

// ==== rtl/uic_params.svh ====
// Purpose: Constants of the UART interrupt and FIFO control block.
// Assumes: Three-bit channel register address on the parallel host bus.
// Notes: Trigger tables pack four 8-bit levels, selection code 0 in the low byte.
`ifndef UIC_PARAMS_SVH
`define UIC_PARAMS_SVH

`define UIC_A_RHR 3'h0
`define UIC_A_IER 3'h1
`define UIC_A_ISR 3'h2
`define UIC_A_LSR 3'h5
`define UIC_A_MSR 3'h6

`define UIC_FCR_EN 0
`define UIC_FCR_RXRST 1
`define UIC_FCR_TXRST 2
`define UIC_FCR_DMA 3
`define UIC_IER_RX 0
`define UIC_IER_TX 1
`define UIC_IER_LS 2
`define UIC_IER_MS 3
`define UIC_IER_XOFF 5
`define UIC_IER_RTS 6
`define UIC_IER_CTS 7

`define UIC_FIFO_DEPTH 8'h80
`define UIC_TO_CHARS 7'h04
`define UIC_TO_BITS 7'h0C

`define UIC_RXTRG_A 32'h0E080401
`define UIC_TXTRG_A 32'h01010101
`define UIC_RXTRG_B 32'h1C181008
`define UIC_TXTRG_B 32'h1E180810
`define UIC_RXTRG_C 32'h3C381008
`define UIC_TXTRG_C 32'h38201008

`define UIC_ISR_LS 6'h06
`define UIC_ISR_RXTO 6'h0C
`define UIC_ISR_RX 6'h04
`define UIC_ISR_TX 6'h02
`define UIC_ISR_MS 6'h00
`define UIC_ISR_XOFF 6'h10
`define UIC_ISR_FC 6'h20
`define UIC_ISR_NONE 6'h01

`endif

// ==== rtl/uic_pkg.sv ====
// Purpose: Types of the UART interrupt and FIFO control block.
// Assumes: Constants come from uic_params.svh.
// Notes: Receiver and transmitter inputs travel as structs.
`include "uic_params.svh"

package uic_pkg;

  typedef enum logic [5:0] {
    UIC_CODE_LS = `UIC_ISR_LS,
    UIC_CODE_RXTO = `UIC_ISR_RXTO,
    UIC_CODE_RX = `UIC_ISR_RX,
    UIC_CODE_TX = `UIC_ISR_TX,
    UIC_CODE_MS = `UIC_ISR_MS,
    UIC_CODE_XOFF = `UIC_ISR_XOFF,
    UIC_CODE_FC = `UIC_ISR_FC,
    UIC_CODE_NONE = `UIC_ISR_NONE
  } uic_code_type;

  typedef struct packed {
    logic [7:0] level;
    logic char_stb;
    logic [3:0] char_err;
    logic overrun;
    logic [2:0] head_err;
    logic fifo_err;
    logic xoff_match;
    logic xon_match;
    logic spec_match;
  } uic_rx_type;

  typedef struct packed {
    logic [7:0] level;
    logic thr_empty;
    logic all_empty;
  } uic_tx_type;

  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic fifo_en;
    logic dma;
    logic [1:0] rx_sel;
    logic [1:0] tx_sel;
    logic rx_rst;
    logic tx_rst;
    logic p_ls;
    logic p_rxto;
    logic p_tx;
    logic p_xoff;
    logic p_spec;
    logic p_fc;
    logic thr_empty_q;
    logic all_empty_q;
    logic tx_empty_q;
    logic tx_above_q;
    logic ier_tx_q;
    logic rts_q;
    logic cts_q;
    logic [6:0] to_cnt;
    logic [7:0] rdata;
    logic irq;
    logic rx_pin_n;
    logic tx_pin_n;
  } uic_state_type;

endpackage : uic_pkg

// ==== bench/uic_host.sv ====
// Purpose: Host processor model on the parallel register bus of the channel.
// Assumes: One access per call; strobes are one-cycle pulses launched at a rising edge.
// Notes: Released address and data lines show the inverse of their last value.
module uic_host
  import uic_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [2:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr_o = 3'h0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end

  // Callers may write fifo_control with bit 0 clear and set upper enables before the enhanced bit is on.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule // uic_host

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench of the interrupt and FIFO control block.
// Assumes: Unit inputs change at rising edges; outputs are sampled at falling edges.
// Notes: Trigger table and programmable levels stay at their defaults.
module tb_top;
  import uic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr;
  logic rd, wr, irq, fen, dma, rxr, txr, rxp, txp;
  logic [7:0] wdata, rdata, d;
  uic_rx_type rx = '0;
  uic_tx_type tx = '{level: 8'h00, thr_empty: 1'b1, all_empty: 1'b1};
  logic [7:0] modem_status_reg = 8'h00;
  logic enhanced_feature_reg = 1'b0, acts = 1'b0, cts = 1'b0, tick = 1'b0, rts = 1'b0;
  int failures = 0, checks = 0;

  always #4 clk_i = ~clk_i;

  uic_host u_uic_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
  uic_top u_uic_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata),
    .rx_i(rx), .tx_i(tx), .msr_i(modem_status_reg), .efr_enable_i(enhanced_feature_reg), .feature_control_reg_table_i(2'h0), .rs485_auto_i(1'b0),
    .auto_rts_i(acts), .auto_cts_i(acts), .rts_out_i(rts), .cts_pin_i(cts), .rx_trg_prog_i(8'h00),
    .tx_trg_prog_i(8'h00), .bit_tick_i(tick), .char_bits_i(4'hA), .rdata_o(rdata), .irq_o(irq),
    .fifo_en_o(fen), .dma_mode_o(dma), .rx_fifo_reset_o(rxr), .tx_fifo_reset_o(txr),
    .receive_ready_pin_n_o(rxp), .transmit_ready_pin_n_o(txp));

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic interrupt_status(output logic [7:0] v);
    u_uic_host.rd(3'h2, v);
  endtask

  task automatic pause(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic t_fifo();
    u_uic_host.wr(3'h2, 8'h03);
    @(negedge clk_i);
    chk("rx_reset", {7'h00, rxr}, 8'h01);
    chk("fifo_en", {7'h00, fen}, 8'h01);
    @(negedge clk_i);
    chk("rx_reset_end", {7'h00, rxr}, 8'h00);
    interrupt_status(d);
    chk("isr_fifo", d, 8'hC1);
    u_uic_host.wr(3'h2, 8'h0C);
    pause(1);
    chk("ignored", {6'h00, fen, dma | txr}, 8'h00);
    u_uic_host.wr(3'h2, 8'h09);
    pause(1);
    chk("dma", {6'h00, fen, dma}, 8'h03);
  endtask

  task automatic t_rx_dma();
    @(posedge clk_i) {rx.char_stb, rx.char_err, rx.level} <= {1'b1, 4'h1, 8'h01};
    @(posedge clk_i) rx.char_stb <= 1'b0;
    pause(3);
    chk("polled_irq", {7'h00, irq}, 8'h00);
    chk("rx_pin_n", {7'h00, rxp}, 8'h00);
    chk("tx_pin_n", {7'h00, txp}, 8'h00);
    u_uic_host.wr(3'h1, 8'h01);
    @(posedge clk_i) tick <= 1'b1;
    u_uic_host.rd(3'h0, d);
    pause(30);
    interrupt_status(d);
    chk("isr_trig", d, 8'hC4);
    pause(40);
    interrupt_status(d);
    chk("isr_tmo", d, 8'hCC);
    u_uic_host.rd(3'h0, d);
    interrupt_status(d);
    chk("isr_tmo_clr", d, 8'hC4);
    @(posedge clk_i) {tick, rx.level, rx.char_err} <= '0;
    u_uic_host.wr(3'h2, 8'h00);
  endtask

  task automatic t_ls();
    u_uic_host.wr(3'h1, 8'h05);
    @(posedge clk_i) {rx.char_stb, rx.char_err, rx.level} <= {1'b1, 4'h8, 8'h01};
    @(posedge clk_i) rx.char_stb <= 1'b0;
    pause(3);
    chk("irq_set", {7'h00, irq}, 8'h01);
    interrupt_status(d);
    chk("isr_ls", d, 8'h06);
    u_uic_host.rd(3'h5, d);
    chk("lsr", d, 8'h61);
    interrupt_status(d);
    chk("isr_rx", d, 8'h04);
    @(posedge clk_i) {rx.level, rx.char_err} <= '0;
    pause(3);
    interrupt_status(d);
    chk("isr_none", d, 8'h01);
    chk("irq_clr", {7'h00, irq}, 8'h00);
  endtask

  task automatic t_ms_tx();
    u_uic_host.wr(3'h1, 8'h08);
    @(posedge clk_i) modem_status_reg <= 8'h04;
    pause(3);
    interrupt_status(d);
    chk("isr_ms", d, 8'h00);
    u_uic_host.rd(3'h6, d);
    chk("msr_read", d, 8'h04);
    @(posedge clk_i) modem_status_reg <= 8'h00;
    pause(2);
    interrupt_status(d);
    chk("isr_ms_clr", d, 8'h01);
    u_uic_host.wr(3'h1, 8'h02);
    pause(3);
    interrupt_status(d);
    chk("isr_tx", d, 8'h02);
    interrupt_status(d);
    chk("isr_tx_rd", d, 8'h01);
    @(posedge clk_i) tx.thr_empty <= 1'b0;
    @(posedge clk_i) tx.thr_empty <= 1'b1;
    pause(3);
    chk("irq_tx", {7'h00, irq}, 8'h01);
    u_uic_host.wr(3'h0, 8'h55);
    pause(3);
    interrupt_status(d);
    chk("isr_tx_wr", d, 8'h01);
  endtask

  task automatic t_upper();
    u_uic_host.wr(3'h1, 8'hA0);
    @(posedge clk_i) rx.xoff_match <= 1'b1;
    @(posedge clk_i) rx.xoff_match <= 1'b0;
    pause(3);
    interrupt_status(d);
    chk("isr_no_efr", d, 8'h01);
    @(posedge clk_i) {enhanced_feature_reg, rx.xoff_match} <= 2'b11;
    @(posedge clk_i) rx.xoff_match <= 1'b0;
    pause(3);
    interrupt_status(d);
    chk("isr_xoff", d, 8'h10);
    interrupt_status(d);
    chk("isr_xoff_clr", d, 8'h01);
    @(posedge clk_i) acts <= 1'b1;
    @(posedge clk_i) cts <= 1'b1;
    pause(6);
    interrupt_status(d);
    chk("isr_fc", d, 8'h20);
    u_uic_host.rd(3'h6, d);
    interrupt_status(d);
    chk("isr_fc_clr", d, 8'h01);
    u_uic_host.wr(3'h1, 8'h40);
    @(posedge clk_i) rts <= 1'b1;
    pause(3);
    interrupt_status(d);
    chk("isr_rts", d, 8'h20);
    u_uic_host.rd(3'h6, d);
    interrupt_status(d);
    chk("isr_rts_clr", d, 8'h01);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    interrupt_status(d);
    chk("isr_reset", d, 8'h01);
    chk("pins_reset", {4'h0, rxp, txp, irq, fen}, 8'h08);
    t_fifo();
    t_rx_dma();
    t_ls();
    t_ms_tx();
    t_upper();
    close_out();
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    close_out();
  end
endmodule // tb_top
